// *** core/ivu_cfg.svh ***
`ifndef IVU_CFG_SVH
`define IVU_CFG_SVH
// Behaviour
// - six requests: three port-3 pins, two timers, one low-voltage detector
// - mask register enables each request and all requests globally
// - port-3 mode bit 1 picks pin three or stop-recovery output for request 1
// - vector pairs: requests 0..5 at locations 0,1 2,3 4,5 6,7 8,9 10,11
// - request 1 falling edge only; requests 3,4,5 from timers and detector
// - programmable priority encoder picks among several pending requests
// - grant starts an interrupt cycle that disables all further interrupts
// - vector byte and next byte form the 16-bit service routine address
// - masked requests still show in the request register for polling
// - comparator one raises request 2, comparator two raises request 0
// - request bits 7:6 choose falling, rising or both edges for requests 2 and 0
// - in halt the cpu clock stops, timers and all six sources stay live
// - only a serviced enabled request ends halt
// - eight-bit timer counter enable gates its terminal-count request
// - eight-bit timer capture enable gates its capture request
// - stop-mode bit 0 enables divide-by-16 prescale, cleared on stop recovery
// - with detection on, low voltage latches request 5 until cleared

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IVU_OFF_REQ        8'hFA
`define IVU_OFF_MASK       8'hFB
`define IVU_OFF_PRIO       8'hF9
`define IVU_OFF_P3M        8'hF7
`define IVU_OFF_SMR        8'hF6
`define IVU_OFF_TCTL       8'hF5
`define IVU_OFF_ST         8'hF0
`define IVU_OFF_CLR        8'hF1
`define IVU_OFF_EN         8'hF2

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define IVU_REQ_D6         6
`define IVU_REQ_D7         7
`define IVU_MASK_GLOBAL    7
`define IVU_P3M_ANALOG     1
`define IVU_SMR_DIV16      0
`define IVU_TCTL_CNT_EN    0
`define IVU_TCTL_CAP_EN    1
`define IVU_TCTL_LVD_EN    2
`define IVU_ST_GRANT       0
`define IVU_ST_WAKE        1
`define IVU_ST_LOWV        2
`define IVU_NUM_REQ        6
`define IVU_PRESC_LAST     4'hF
`define IVU_RST_BYTE       8'h00
`define IVU_PIN_IDLE       5'h0F
`endif

// *** core/ivu_pkg.sv ***
package ivu_pkg;
	typedef enum logic [1:0] {
		IVU_IDLE,
		IVU_FETCH_HI,
		IVU_FETCH_LO,
		IVU_BRANCH
	} ivu_state_t;
endpackage : ivu_pkg

// *** core/ivu_unit.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`include "ivu_cfg.svh"
module ivu_unit #(
	parameter int NREQ = `IVU_NUM_REQ
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	// external pins, asynchronous
	input  wire logic        port3_pin_one_i,
	input  wire logic        port3_pin_two_i,
	input  wire logic        port3_pin_three_i,
	input  wire logic        stop_src_i,
	input  wire logic        low_voltage_i,
	// internal events, same clock
	input  wire logic        comp_one_evt_i,
	input  wire logic        comp_two_evt_i,
	input  wire logic        timer16_tc_i,
	input  wire logic        timer8_tc_i,
	input  wire logic        timer8_cap_i,
	input  wire logic        stop_recovery_i,
	// cpu sequencer
	input  wire logic        halt_i,
	input  wire logic        int_ack_i,
	input  wire logic [7:0]  mem_data_i,
	output logic             int_req_o,
	output logic             int_cycle_o,
	output logic             mem_rd_o,
	output logic      [15:0] mem_addr_o,
	output logic      [15:0] isr_addr_o,
	output logic             isr_valid_o,
	output logic             cpu_clk_run_o,
	output logic             prescale_o,
	output logic             irq_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] pick(input logic [5:0] elig, input logic [2:0] top);
		logic [2:0] sel;
		logic [2:0] idx;
		logic       found;
		sel   = 3'h0;
		found = 1'b0;
		for (int i = 0; i < NREQ; i++) begin
			idx = 3'((int'(top) + i) % NREQ);
			if (!found && elig[idx]) begin
				sel   = idx;
				found = 1'b1;
			end
		end
		return sel;
	endfunction : pick

	function automatic logic edge_sel(input logic rise, input logic fall,
		input logic both, input logic use_rise);
		return both ? (rise | fall) : (use_rise ? rise : fall);
	endfunction : edge_sel

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] sync_a_reg;
	logic [4:0] sync_b_reg;
	logic [4:0] sync_c_reg;
	logic [4:0] pin_reg;
	logic [4:0] pin_prev_reg;
	logic [4:0] rise;
	logic [4:0] fall;

	// reset to the idle level, else release looks like a falling edge
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			sync_a_reg <= `IVU_PIN_IDLE;
			sync_b_reg <= `IVU_PIN_IDLE;
			sync_c_reg <= `IVU_PIN_IDLE;
		end else begin
			sync_a_reg <= {low_voltage_i, stop_src_i, port3_pin_three_i,
				port3_pin_two_i, port3_pin_one_i};
			sync_b_reg <= sync_a_reg;
			sync_c_reg <= sync_b_reg;
		end
	end

	// port-3 and stop pins idle high, low-voltage idles low; a change counts only once two stages agree
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			pin_reg      <= `IVU_PIN_IDLE;
			pin_prev_reg <= `IVU_PIN_IDLE;
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (sync_b_reg[i] == sync_c_reg[i])
					pin_reg[i] <= sync_c_reg[i];
			end
			pin_prev_reg <= pin_reg;
		end
	end

	assign rise = pin_reg & ~pin_prev_reg;
	assign fall = ~pin_reg & pin_prev_reg;

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [7:0] edge_reg;
	logic [7:0] mask_reg;
	logic [2:0] prio_reg;
	logic       p3m_analog_reg;
	logic       div16_reg;
	logic [2:0] tctl_reg;
	logic [2:0] st_en_reg;
	logic       wr_req;
	logic       grant;
	ivu_pkg::ivu_state_t state_reg;

	assign wr_req = wr_i && (addr_i == `IVU_OFF_REQ);
	assign grant  = int_req_o && int_ack_i && (state_reg == ivu_pkg::IVU_IDLE);

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			edge_reg <= `IVU_RST_BYTE;
		end else if (wr_req) begin
			edge_reg <= wdata_i;
		end
	end

	// grant drops the global enable so nothing nests by accident
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			mask_reg <= `IVU_RST_BYTE;
		end else if (grant) begin
			mask_reg[`IVU_MASK_GLOBAL] <= 1'b0;
		end else if (wr_i && addr_i == `IVU_OFF_MASK) begin
			mask_reg <= wdata_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			prio_reg       <= 3'h0;
			p3m_analog_reg <= 1'b0;
			tctl_reg       <= 3'h0;
			st_en_reg      <= 3'h0;
		end else if (wr_i) begin
			case (addr_i)
				`IVU_OFF_PRIO: prio_reg       <= wdata_i[2:0];
				`IVU_OFF_P3M:  p3m_analog_reg <= wdata_i[`IVU_P3M_ANALOG];
				`IVU_OFF_TCTL: tctl_reg       <= wdata_i[2:0];
				`IVU_OFF_EN:   st_en_reg      <= wdata_i[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			div16_reg <= 1'b0;
		end else if (stop_recovery_i) begin
			div16_reg <= 1'b0;
		end else if (wr_i && addr_i == `IVU_OFF_SMR) begin
			div16_reg <= wdata_i[`IVU_SMR_DIV16];
		end
	end

	// ----------------------------------------------------------------
	// prescaler: slows priority evaluation, events still latch
	// ----------------------------------------------------------------
	logic [3:0] presc_reg;
	logic       tick;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			presc_reg <= 4'h0;
		end else begin
			presc_reg <= presc_reg + 4'h1;
		end
	end

	assign tick = !div16_reg || (presc_reg == `IVU_PRESC_LAST);

	// ----------------------------------------------------------------
	// request register
	// ----------------------------------------------------------------
	logic [5:0] evt;
	logic [5:0] req_reg;
	logic [5:0] req_next;
	logic [5:0] elig;
	logic [2:0] sel_reg;

	always_comb begin
		evt    = 6'h00;
		evt[0] = edge_sel(rise[1], fall[1], edge_reg[`IVU_REQ_D7] & edge_reg[`IVU_REQ_D6],
			edge_reg[`IVU_REQ_D6]) | comp_two_evt_i;
		evt[1] = p3m_analog_reg ? fall[3] : fall[2];
		evt[2] = edge_sel(rise[0], fall[0], edge_reg[`IVU_REQ_D7] & edge_reg[`IVU_REQ_D6],
			edge_reg[`IVU_REQ_D7]) | comp_one_evt_i;
		evt[3] = timer16_tc_i;
		evt[4] = (timer8_tc_i & tctl_reg[`IVU_TCTL_CNT_EN])
			| (timer8_cap_i & tctl_reg[`IVU_TCTL_CAP_EN]);
		evt[5] = tctl_reg[`IVU_TCTL_LVD_EN] & pin_reg[4];
	end

	// event beats a same-cycle clear, mask plays no part here
	always_comb begin
		req_next = wr_req ? wdata_i[5:0] : req_reg;
		if (grant)
			req_next[sel_reg] = 1'b0;
		req_next = req_next | evt;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			req_reg <= 6'h00;
		end else begin
			req_reg <= req_next;
		end
	end

	assign elig = req_reg & mask_reg[5:0] & {6{mask_reg[`IVU_MASK_GLOBAL]}};

	// ----------------------------------------------------------------
	// grant and vector fetch
	// ----------------------------------------------------------------
	logic [7:0] hi_reg;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			int_req_o <= 1'b0;
			sel_reg   <= 3'h0;
		end else if (state_reg != ivu_pkg::IVU_IDLE || grant) begin
			int_req_o <= 1'b0;
		end else if (tick) begin
			int_req_o <= |elig;
			sel_reg   <= pick(elig, (int'(prio_reg) < NREQ) ? prio_reg : 3'h0);
		end
	end

	// high byte at the vector, low byte after it
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_reg   <= ivu_pkg::IVU_IDLE;
			mem_rd_o    <= 1'b0;
			mem_addr_o  <= 16'h0000;
			hi_reg      <= 8'h00;
			isr_addr_o  <= 16'h0000;
			isr_valid_o <= 1'b0;
			int_cycle_o <= 1'b0;
		end else begin
			isr_valid_o <= 1'b0;
			case (state_reg)
				ivu_pkg::IVU_IDLE: begin
					if (grant) begin
						state_reg   <= ivu_pkg::IVU_FETCH_HI;
						int_cycle_o <= 1'b1;
						mem_rd_o    <= 1'b1;
						mem_addr_o  <= {12'h000, sel_reg, 1'b0};
					end
				end
				ivu_pkg::IVU_FETCH_HI: begin
					state_reg  <= ivu_pkg::IVU_FETCH_LO;
					mem_addr_o <= mem_addr_o + 16'h0001;
				end
				ivu_pkg::IVU_FETCH_LO: begin
					state_reg <= ivu_pkg::IVU_BRANCH;
					mem_rd_o  <= 1'b0;
					hi_reg    <= mem_data_i;
				end
				ivu_pkg::IVU_BRANCH: begin
					state_reg   <= ivu_pkg::IVU_IDLE;
					int_cycle_o <= 1'b0;
					isr_addr_o  <= {hi_reg, mem_data_i};
					isr_valid_o <= 1'b1;
				end
				default: state_reg <= ivu_pkg::IVU_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// halt: cpu clock stops, sources keep running
	// ----------------------------------------------------------------
	logic halted_reg;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			halted_reg <= 1'b0;
		end else if (grant) begin
			halted_reg <= 1'b0;
		end else if (halt_i) begin
			halted_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			cpu_clk_run_o <= 1'b1;
			prescale_o    <= 1'b0;
		end else begin
			cpu_clk_run_o <= !(halted_reg && !grant) && !halt_i;
			prescale_o    <= div16_reg;
		end
	end

	// ----------------------------------------------------------------
	// sticky status and interrupt line
	// ----------------------------------------------------------------
	logic [2:0] st_reg;
	logic [2:0] st_set;
	logic [2:0] st_clr;

	assign st_set = {evt[5], grant & halted_reg, grant};
	assign st_clr = (wr_i && addr_i == `IVU_OFF_CLR) ? wdata_i[2:0] : 3'h0;

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			st_reg <= 3'h0;
			irq_o  <= 1'b0;
		end else begin
			st_reg <= (st_reg & ~st_clr) | st_set;
			irq_o  <= |(((st_reg & ~st_clr) | st_set) & st_en_reg);
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`IVU_OFF_REQ:  rdata_o <= {edge_reg[7:6], req_reg};
				`IVU_OFF_MASK: rdata_o <= mask_reg;
				`IVU_OFF_PRIO: rdata_o <= {5'h00, prio_reg};
				`IVU_OFF_P3M:  rdata_o <= {6'h00, p3m_analog_reg, 1'b0};
				`IVU_OFF_SMR:  rdata_o <= {7'h00, div16_reg};
				`IVU_OFF_TCTL: rdata_o <= {5'h00, tctl_reg};
				`IVU_OFF_ST:   rdata_o <= {5'h00, st_reg};
				`IVU_OFF_EN:   rdata_o <= {5'h00, st_en_reg};
				default:       rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	grant_kills_global_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		grant |=> !mask_reg[`IVU_MASK_GLOBAL])
		else $error("global enable survived a grant");

	fetch_order_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		grant |=> mem_rd_o && mem_addr_o == {12'h000, $past(sel_reg), 1'b0}
			##1 mem_rd_o && mem_addr_o == {12'h000, $past(sel_reg, 2), 1'b1})
		else $error("vector fetch address wrong");

	isr_pair_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		grant |-> ##4 isr_valid_o && isr_addr_o == {$past(mem_data_i, 2), $past(mem_data_i)})
		else $error("service address not ready four cycles after grant");

	req_only_enabled_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$rose(int_req_o) |-> $past(mask_reg[`IVU_MASK_GLOBAL]) && $past(|elig))
		else $error("request raised without enable");

	poll_keeps_req_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		req_reg[3] && !wr_req && !grant |=> req_reg[3])
		else $error("pending request lost");

	timer16_sets_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		timer16_tc_i |=> req_reg[3])
		else $error("timer event did not latch");

	halt_exit_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		halted_reg && !grant && !halt_i |=> !cpu_clk_run_o)
		else $error("halt ended without a grant");

	div16_clear_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		stop_recovery_i |=> !div16_reg ##1 !prescale_o)
		else $error("prescale not cleared on recovery");

	lowv_latch_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		tctl_reg[`IVU_TCTL_LVD_EN] && pin_reg[4] |=> req_reg[5])
		else $error("low voltage did not set request 5");
endmodule : ivu_unit

// *** tb/ivu_cpu_model.sv ***
`timescale 1ns/1ns
module ivu_cpu_model (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	// from the interrupt unit
	input  wire logic        int_req_i,
	input  wire logic        mem_rd_i,
	input  wire logic [15:0] mem_addr_i,
	// bench control
	input  wire logic [1:0]  ack_dly_i,
	// to the interrupt unit
	output logic             int_ack_o,
	output logic      [7:0]  mem_data_o
);
	logic [1:0] wait_reg;

	// one-cycle ack, only while a request is shown
	always_ff @(posedge clock_i) begin
		if (!rst_b_i || int_ack_o || !int_req_i) begin
			int_ack_o <= 1'b0;
			wait_reg  <= 2'h0;
		end else if (wait_reg == ack_dly_i) begin
			int_ack_o <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 2'h1;
		end
	end

	// idle bus toggles so a stale byte is never mistaken for a fetch
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			mem_data_o <= 8'h5A;
		end else if (mem_rd_i) begin
			mem_data_o <= {mem_addr_i[3:0], ~mem_addr_i[3:0]};
		end else begin
			mem_data_o <= ~mem_data_o;
		end
	end
endmodule : ivu_cpu_model

// *** tb/test_six_source_vectored_interrupt_unit.sv ***
`timescale 1ns/1ns
module test_six_source_vectored_interrupt_unit;
	logic        clock_i;
	logic        rst_b_i;
	logic        wr_i;
	logic        rd_i;
	logic [7:0]  addr_i;
	logic [7:0]  wdata_i;
	logic [7:0]  rdata_o;
	logic [7:0]  mem_data;
	logic [7:0]  rv;
	logic [5:0]  evt;
	logic [4:0]  pins;
	logic        halt;
	logic        ack;
	logic [1:0]  ack_dly;
	logic        int_req;
	logic        int_cyc;
	logic        mem_rd;
	logic [15:0] mem_addr;
	logic [15:0] isr_addr;
	logic        isr_valid;
	logic        clk_run;
	logic        prescale;
	logic        irq;
	logic [5:0]  pend;
	logic [5:0]  msk;
	logic [2:0]  prio;
	int          sel;
	int          n_fail;
	int          tests_run;
	logic [7:0]  offs [9] = '{8'hFA, 8'hFB, 8'hF9, 8'hF7, 8'hF6, 8'hF5, 8'hF0, 8'hF2, 8'h10};
	// event index, timer control, expected request byte
	logic [23:0] ev_tab [8] = '{24'h000004, 24'h010001, 24'h020008, 24'h030000,
		24'h030110, 24'h040000, 24'h040100, 24'h040210};

	ivu_unit i_ivu_unit (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.port3_pin_one_i(pins[0]), .port3_pin_two_i(pins[1]), .port3_pin_three_i(pins[2]),
		.stop_src_i(pins[3]), .low_voltage_i(pins[4]),
		.comp_one_evt_i(evt[0]), .comp_two_evt_i(evt[1]), .timer16_tc_i(evt[2]),
		.timer8_tc_i(evt[3]), .timer8_cap_i(evt[4]), .stop_recovery_i(evt[5]),
		.halt_i(halt), .int_ack_i(ack), .mem_data_i(mem_data), .int_req_o(int_req),
		.int_cycle_o(int_cyc), .mem_rd_o(mem_rd), .mem_addr_o(mem_addr), .isr_addr_o(isr_addr),
		.isr_valid_o(isr_valid), .cpu_clk_run_o(clk_run), .prescale_o(prescale), .irq_o(irq)
	);

	ivu_cpu_model i_ivu_cpu_model (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .int_req_i(int_req), .mem_rd_i(mem_rd),
		.mem_addr_i(mem_addr), .ack_dly_i(ack_dly), .int_ack_o(ack), .mem_data_o(mem_data)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] vec(input int s);
		logic [7:0] a;
		logic [7:0] b;
		a = 8'(2 * s);
		b = a + 8'h01;
		return {a[3:0], ~a[3:0], b[3:0], ~b[3:0]};
	endfunction : vec

	function automatic int pick(input logic [5:0] p, input logic [2:0] pr);
		int top;
		top = (pr > 3'h5) ? 0 : int'(pr);
		for (int i = 0; i < 6; i++) begin
			if (p[(top + i) % 6]) return (top + i) % 6;
		end
		return 0;
	endfunction : pick

	function automatic logic edge_hit(input int c, input int k, input int v);
		logic b;
		b = k ? c[0] : c[1];
		return (c == 3) || (v ? b : !b);
	endfunction : edge_hit

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chkf(input string what, input logic exp, input logic got);
		chk(what, {15'h0000, exp}, {15'h0000, got});
	endtask : chkf

	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
		chk(what, {8'h00, exp}, {8'h00, rv});
	endtask : rchk

	// pins pass a synchroniser, so let them settle before polling
	task automatic setpin(input int k, input logic v);
		@(posedge clock_i);
		pins[k] <= v;
		idle(8);
	endtask : setpin

	task automatic pulse(input int k);
		@(posedge clock_i);
		evt[k] <= 1'b1;
		@(posedge clock_i);
		evt[k] <= 1'b0;
	endtask : pulse

	task automatic wait_isr();
		int   n;
		logic seen;
		n    = 0;
		seen = 1'b0;
		while (isr_valid !== 1'b1 && n < 60) begin
			idle(1);
			seen = seen | (int_cyc === 1'b1);
			n++;
		end
		chkf("isr valid", 1'b1, isr_valid);
		chkf("interrupt cycle seen", 1'b1, seen);
		chkf("interrupt cycle over", 1'b0, int_cyc);
	endtask : wait_isr

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	initial begin
		#80000;
		n_fail++;
		tally_and_finish();
	end

	initial begin
		rst_b_i   = 1'b0;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		addr_i    = 8'h00;
		wdata_i   = 8'h00;
		evt       = 6'h00;
		pins      = 5'h0F;
		halt      = 1'b0;
		ack_dly   = 2'h0;
		n_fail    = 0;
		tests_run = 0;
		void'($urandom(89662));
		// three edges of reset; the synchroniser starts at the idle level
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		idle(1);
		chkf("run at reset", 1'b1, clk_run);
		wr(8'h10, 8'hFF);
		wr(8'hF0, 8'hFF);
		foreach (offs[i]) rchk("reset value", offs[i], 8'h00);
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 2; k++) begin
				for (int v = 0; v < 2; v++) begin
					wr(8'hFA, 8'(c << 6));
					setpin(k, v[0]);
					rchk("edge", 8'hFA, 8'(c << 6) | (edge_hit(c, k, v) ? (k ? 8'h01 : 8'h04) : 8'h00));
				end
			end
		end
		wr(8'hFA, 8'h00);
		setpin(2, 1'b0);
		rchk("req1 fall", 8'hFA, 8'h02);
		wr(8'hFA, 8'h00);
		setpin(2, 1'b1);
		rchk("req1 rise", 8'hFA, 8'h00);
		wr(8'hF7, 8'h02);
		setpin(2, 1'b0);
		rchk("pin in analog", 8'hFA, 8'h00);
		setpin(3, 1'b0);
		rchk("stop source", 8'hFA, 8'h02);
		setpin(3, 1'b1);
		setpin(2, 1'b1);
		wr(8'hF7, 8'h00);
		foreach (ev_tab[i]) begin
			wr(8'hF5, ev_tab[i][15:8]);
			wr(8'hFA, 8'h00);
			pulse(int'(ev_tab[i][18:16]));
			rchk("event", 8'hFA, ev_tab[i][7:0]);
		end
		for (int e = 0; e < 2; e++) begin
			wr(8'hF5, 8'(e << 2));
			wr(8'hFA, 8'h00);
			setpin(4, 1'b1);
			setpin(4, 1'b0);
			rchk("low voltage", 8'hFA, e ? 8'h20 : 8'h00);
		end
		wr(8'hF5, 8'h00);
		wr(8'hF1, 8'hFF);
		wr(8'hF2, 8'h01);
		for (int t = 0; t < 12; t++) begin
			pend = (t == 0) ? 6'h3F : (t == 1) ? 6'h21 : 6'($urandom());
			if (pend == 6'h00) pend = 6'h10;
			msk = (t == 0) ? 6'h3F : (t == 1) ? 6'h20 : 6'($urandom()) | (pend & (~pend + 6'h01));
			prio = (t == 0) ? 3'h7 : (t == 1) ? 3'h1 : 3'($urandom());
			ack_dly <= 2'($urandom());
			sel = pick(pend & msk, prio);
			wr(8'hFA, {2'b00, pend});
			wr(8'hF9, {5'h00, prio});
			wr(8'hFB, {2'b10, msk});
			wait_isr();
			chk("isr address", vec(sel), isr_addr);
			chkf("no new request", 1'b0, int_req);
			rchk("pending after grant", 8'hFA, {2'b00, pend & ~(6'h01 << sel)});
			rchk("mask after grant", 8'hFB, {2'b00, msk});
			chkf("grant irq", 1'b1, irq);
			wr(8'hF1, 8'h01);
			idle(2);
			chkf("irq cleared", 1'b0, irq);
		end
		wr(8'hFA, 8'h00);
		wr(8'hF1, 8'hFF);
		wr(8'hF2, 8'h00);
		@(posedge clock_i);
		halt <= 1'b1;
		@(posedge clock_i);
		halt <= 1'b0;
		#1 chkf("halted", 1'b0, clk_run);
		pulse(2);
		rchk("event in halt", 8'hFA, 8'h08);
		chkf("masked stays halted", 1'b0, clk_run);
		wr(8'hFB, 8'h88);
		wait_isr();
		chk("halt isr", vec(3), isr_addr);
		idle(2);
		chkf("woken", 1'b1, clk_run);
		rchk("status", 8'hF0, 8'h03);
		chkf("irq disabled", 1'b0, irq);
		wr(8'hF2, 8'h02);
		idle(2);
		chkf("irq wake", 1'b1, irq);
		wr(8'hF1, 8'h02);
		idle(2);
		chkf("irq clear", 1'b0, irq);
		wr(8'hF6, 8'h01);
		idle(2);
		chkf("prescale on", 1'b1, prescale);
		wr(8'hFA, 8'h10);
		wr(8'hFB, 8'h90);
		wait_isr();
		chk("slow isr", vec(4), isr_addr);
		pulse(5);
		idle(2);
		chkf("prescale off", 1'b0, prescale);
		rchk("stop mode", 8'hF6, 8'h00);
		tally_and_finish();
	end
endmodule : test_six_source_vectored_interrupt_unit
